/* File: hw/kswd_top.sv */
// kswd_top: one-time enabled watchdog with key restart and reset-out pulse.
// assumes: clk_sys is the oscillator; sfr strobes are synchronous to it.
`timescale 1ns/10ps
module kswd_top
    import kswd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        osc_run,
    input  wire logic        clk_mode_x6,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    output logic             wd_armed,
    output logic             dev_rst,
    output logic             rst_pin_o,
    output logic             rst_pin_oe
);
    import kswd_pkg::*;

    kswd_pulse_if pif ();

    logic                  enabled_r;
    logic                  key_half_r;
    logic [KSWD_CNT_W-1:0] cnt_r;
    logic [KSWD_MC_W-1:0]  mc_r;
    logic                  mc_tick;
    logic                  key_wr;
    logic                  key_done;
    logic                  ovf;
    logic [7:0]            rdata_r;

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    function automatic logic is_key(input logic [7:0] a);
        return a == KSWD_ADDR_RESTART_KEY;
    endfunction

    assign key_wr   = sfr_wr && is_key(sfr_addr);
    // stray second byte ignored unless the previous key-address write was the first byte
    assign key_done = key_wr && key_half_r && sfr_wdata == KSWD_KEY_SECOND;
    assign ovf      = enabled_r && cnt_r == KSWD_CNT_OVF;

    // ------------------------------------------------------------
    // machine-cycle prescaler
    // ------------------------------------------------------------
    // oscillator stopped means osc_run low: no tick, count frozen
    assign mc_tick = osc_run &&
                     mc_r == (clk_mode_x6 ? KSWD_MC_LEN_X6 : KSWD_MC_LEN_X12) - 4'h1;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mc_r <= KSWD_MC_RESET;
        end else if (mc_tick) begin
            mc_r <= KSWD_MC_RESET;
        end else if (osc_run) begin
            mc_r <= mc_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // key sequence tracker
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            key_half_r <= 1'b0;
        end else if (ovf || pif.busy) begin
            key_half_r <= 1'b0;
        end else if (key_wr) begin
            key_half_r <= (sfr_wdata == KSWD_KEY_FIRST);
        end
    end

    // ------------------------------------------------------------
    // enable: set by the key, cleared by reset or by overflow
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            enabled_r <= 1'b0;
        end else if (ovf) begin
            enabled_r <= 1'b0;
        end else if (key_done && !pif.busy) begin
            enabled_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // watchdog counter
    // ------------------------------------------------------------
    // no load path from the bus; cleared by the key pair, by overflow and while disabled
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= KSWD_CNT_RESET;
        end else if (ovf || !enabled_r) begin
            cnt_r <= KSWD_CNT_RESET;
        end else if (key_done) begin
            cnt_r <= KSWD_CNT_RESET;
        end else if (mc_tick) begin
            cnt_r <= cnt_r + 14'h0001;
        end
    end

    // ------------------------------------------------------------
    // reset out
    // ------------------------------------------------------------
    assign pif.start = ovf;
    assign pif.mode  = clk_mode_x6 ? KSWD_MODE_X6 : KSWD_MODE_X12;

    kswd_pulse_gen u_pulse (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pif     (pif)
    );

    // pin only ever driven high; released otherwise for the external pull-down
    assign rst_pin_o  = 1'b1;
    assign rst_pin_oe = pif.busy;
    assign dev_rst    = pif.busy;

    assign wd_armed = enabled_r;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // reads of the key address return zero, never the count
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 8'h00;
        end else if (sfr_rd && is_key(sfr_addr)) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign sfr_rdata = rdata_r;

endmodule

/* File: hw/kswd_pkg.sv */
// kswd_pkg: constants shared by the key-sequence watchdog files.
// assumes: one oscillator clock; pulse and prescaler counts are in oscillator periods, the watchdog count in machine cycles.
package kswd_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  KSWD_ADDR_RESTART_KEY = 8'hA6;
    localparam logic [7:0]  KSWD_KEY_FIRST        = 8'h1E;
    localparam logic [7:0]  KSWD_KEY_SECOND       = 8'hE1;

    // ------------------------------------------------------------
    // counter and timing
    // ------------------------------------------------------------
    localparam int          KSWD_CNT_W            = 14;
    localparam logic [13:0] KSWD_CNT_RESET        = 14'h0000;
    localparam logic [13:0] KSWD_CNT_OVF          = 14'h3FFF;
    localparam int          KSWD_MC_W             = 4;
    localparam logic [3:0]  KSWD_MC_LEN_X6        = 4'h6;
    localparam logic [3:0]  KSWD_MC_LEN_X12       = 4'hC;
    localparam logic [3:0]  KSWD_MC_RESET         = 4'h0;
    localparam int          KSWD_PULSE_W          = 8;
    localparam logic [7:0]  KSWD_PULSE_X6         = 8'h62;
    localparam logic [7:0]  KSWD_PULSE_X12        = 8'hC4;
    localparam logic [7:0]  KSWD_PULSE_RESET      = 8'h00;

    typedef enum logic {KSWD_MODE_X12, KSWD_MODE_X6} kswd_mode_t;

endpackage

/* File: hw/kswd_pulse_if.sv */
// kswd_pulse_if: start/busy link between watchdog core and pulse generator.
// assumes: both ends on clk_sys.
`timescale 1ns/10ps
interface kswd_pulse_if;
    import kswd_pkg::*;
    logic       start;
    kswd_mode_t mode;
    logic       busy;
    modport gen (input start, input mode, output busy);
    modport ctl (output start, output mode, input busy);
endinterface

/* File: hw/kswd_pulse_gen.sv */
// kswd_pulse_gen: counts out the outward reset pulse length.
// assumes: clk_sys is the oscillator; cleared only by arst_n.
`timescale 1ns/10ps
module kswd_pulse_gen
    import kswd_pkg::*;
(
    input  wire logic   clk_sys,
    input  wire logic   arst_n,
    kswd_pulse_if.gen   pif
);

    logic [KSWD_PULSE_W-1:0] left_r;

    // ------------------------------------------------------------
    // pulse counter
    // ------------------------------------------------------------
    // not cleared by the overflow reset it announces, so it runs to length
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            left_r <= KSWD_PULSE_RESET;
        end else if (pif.start && left_r == KSWD_PULSE_RESET) begin
            left_r <= (pif.mode == KSWD_MODE_X6) ? KSWD_PULSE_X6 : KSWD_PULSE_X12;
        end else if (left_r != KSWD_PULSE_RESET) begin
            left_r <= left_r - 8'h01;
        end
    end

    assign pif.busy = (left_r != KSWD_PULSE_RESET);

endmodule

/* File: dv/kswd_props.sv */
// kswd_props: port assertions for kswd_top.
// assumes: one clock domain; bound into kswd_top.
`timescale 1ns/10ps
module kswd_props
    import kswd_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic       clk_mode_x6,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       wd_armed,
    input wire logic       dev_rst,
    input wire logic       rst_pin_o,
    input wire logic       rst_pin_oe
);
    logic       kw;
    logic       k2;
    logic [7:0] last_r;
    logic [7:0] len_r;
    logic       x6_r;
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // mirror of last key byte; writes during pulse are dropped
    assign kw = sfr_wr && sfr_addr == KSWD_ADDR_RESTART_KEY && !dev_rst;
    assign k2 = kw && sfr_wdata == KSWD_KEY_SECOND;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            last_r <= 8'h00;
            len_r  <= 8'h00;
            x6_r   <= 1'b0;
        end else begin
            last_r <= dev_rst ? 8'h00 : (kw ? sfr_wdata : last_r);
            len_r  <= rst_pin_oe ? len_r + 8'h01 : 8'h00;
            x6_r   <= rst_pin_oe ? x6_r : clk_mode_x6;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_pair_arms: assert property (k2 && last_r == KSWD_KEY_FIRST |=> wd_armed || rst_pin_oe)
        else $error("key pair did not arm");
    a_stray_ignored: assert property (k2 && last_r != KSWD_KEY_FIRST && !wd_armed |=> !wd_armed)
        else $error("stray second key armed");
    a_stays_off: assert property (!wd_armed && !k2 |=> !wd_armed)
        else $error("armed without key");
    a_no_sw_off: assert property ($fell(wd_armed) |-> $rose(rst_pin_oe))
        else $error("disarmed without overflow");
    a_ovf_cause: assert property ($rose(rst_pin_oe) |-> $past(wd_armed))
        else $error("pulse while disarmed");
    a_pin_high: assert property (rst_pin_oe |-> rst_pin_o && dev_rst)
        else $error("reset pin not high");
    a_pulse_len: assert property ($fell(rst_pin_oe) |->
        len_r == (x6_r ? KSWD_PULSE_X6 : KSWD_PULSE_X12))
        else $error("pulse length wrong");
    a_pulse_solid: assert property ($rose(rst_pin_oe) |=> rst_pin_oe [*8])
        else $error("pulse cut short");
    a_read_none: assert property (sfr_rdata == 8'h00)
        else $error("read shows state");
endmodule
bind kswd_top kswd_props u_props (.clk_sys(clk_sys), .arst_n(arst_n),
    .clk_mode_x6(clk_mode_x6), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .wd_armed(wd_armed), .dev_rst(dev_rst), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe));

/* File: dv/tb_kswd_top.sv */
// tb_kswd_top: self-checking bench for kswd_top.
// assumes: package and design compiled first; 6-clock counting, 12-clock for the last tick.
`timescale 1ns/10ps
module tb_kswd_top;
    import kswd_pkg::*;
    logic       clk_sys    = 1'b0;
    logic       arst_n     = 1'b0;
    logic       osc_run    = 1'b1;
    logic       mode_x6    = 1'b1;
    logic       sfr_wr     = 1'b0;
    logic       sfr_rd     = 1'b0;
    logic [7:0] sfr_addr   = 8'h00;
    logic [7:0] sfr_wdata  = 8'h00;
    logic [7:0] sfr_rdata;
    logic       wd_armed;
    logic       dev_rst;
    logic       rst_pin_o;
    logic       rst_pin_oe;
    int         errors     = 0;
    int         n_compared = 0;
    int         n;
    always #10 clk_sys = ~clk_sys;
    kswd_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .osc_run(osc_run), .clk_mode_x6(mode_x6),
        .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .wd_armed(wd_armed), .dev_rst(dev_rst),
        .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe));
    task complete_run;
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_wr    <= 1'b1;
        sfr_addr  <= a;
        sfr_wdata <= d;
    endtask
    task idle(input int c);
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    task arm;
        wr(KSWD_ADDR_RESTART_KEY, KSWD_KEY_FIRST);
        wr(KSWD_ADDR_RESTART_KEY, KSWD_KEY_SECOND);
    endtask
    task t_keys;
        chk(wd_armed === 1'b0 && rst_pin_oe === 1'b0 && dev_rst === 1'b0, "reset");
        wr(KSWD_ADDR_RESTART_KEY, KSWD_KEY_SECOND);
        wr(KSWD_ADDR_RESTART_KEY, KSWD_KEY_FIRST);
        wr(KSWD_ADDR_RESTART_KEY, 8'h55);
        wr(KSWD_ADDR_RESTART_KEY, KSWD_KEY_SECOND);
        idle(2);
        chk(wd_armed === 1'b0, "stray key armed");
        wr(KSWD_ADDR_RESTART_KEY, KSWD_KEY_FIRST);
        wr(8'hA0, KSWD_KEY_SECOND);
        wr(KSWD_ADDR_RESTART_KEY, KSWD_KEY_SECOND);
        sfr_rd <= 1'b1;
        idle(1);
        chk(wd_armed === 1'b1 && sfr_rdata === 8'h00, "arm or read");
        wr(KSWD_ADDR_RESTART_KEY, 8'h00);
        idle(20);
        chk(wd_armed === 1'b1, "software disarm");
        @(posedge clk_sys);
        arst_n <= 1'b0;
        idle(2);
        @(posedge clk_sys);
        arst_n <= 1'b1;
        idle(3);
        chk(wd_armed === 1'b0, "reset kept arm");
    endtask
    // service then freeze: both must push overflow later, window is narrower than either
    task t_ovf;
        arm;
        idle(300);
        arm;
        @(posedge clk_sys);
        sfr_wr  <= 1'b0;
        osc_run <= 1'b0;
        repeat (500) @(posedge clk_sys);
        osc_run <= 1'b1;
        n = 500;
        // only one overflow fits the run: switch to 12-clock late, so the long pulse is seen
        while (dev_rst !== 1'b1 && n < 100000) begin
            @(posedge clk_sys);
            n++;
            if (n == 16383 * 6 + 494)
                mode_x6 <= 1'b0;
            #1;
        end
        chk(n >= 16383 * 6 + 494 && n <= 16383 * 6 + 514, "overflow time");
        if (n >= 100000)
            complete_run;
        chk(wd_armed === 1'b0 && rst_pin_o === 1'b1 && rst_pin_oe === 1'b1, "ovf");
        n = 0;
        while (rst_pin_oe === 1'b1 && n < 300) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(n == int'(KSWD_PULSE_X12) && dev_rst === 1'b0 && wd_armed === 1'b0, "pulse");
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        #1;
        t_keys;
        t_ovf;
        complete_run;
    end
endmodule
